// file: trp_pkg.sv
// trip select and action package: register map, fields, encodings
// How it works
// - any enabled trip input driven low raises the cycle trip
// - an active cycle trip applies its configured override to both outputs
// - the cycle trip clears by itself when the counter reaches zero with no trip source active
// - source select bit 7 enables compare B event 2 as cycle trip source
// - source select bit 6 enables compare A event 2 as cycle trip source
// - source select bits 5..0 enable trip inputs 6..1 as sources
// - action bits 1-0 on output A: hi-z, high, low, no action
// - action bits 3-2 on output B with the same encoding
// - action bits 5-4 act on output A for compare A event 1
// - action bits 7-6 act on output A for compare A event 2
// - action bits 9-8 act on output B for compare B event 1
// - action bits 11-10 act on output B for compare B event 2
package trp_pkg;
    // ==================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_SRC_SEL = 12'h000;
    localparam logic [11:0] OFS_ACT_CTL = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_CLEAR = 12'h00c;
    localparam logic [11:0] OFS_INT_EN = 12'h010;
    localparam logic [11:0] OFS_TRIP_STATE = 12'h014;
    // ==================================================
    // field positions
    localparam int SEL_TRIP_LSB = 0;
    localparam int SEL_CMP_A2 = 6;
    localparam int SEL_CMP_B2 = 7;
    localparam int SEL_WIDTH = 8;
    localparam int ACT_TRIP_A = 0;
    localparam int ACT_TRIP_B = 2;
    localparam int ACT_CMP_A1 = 4;
    localparam int ACT_CMP_A2 = 6;
    localparam int ACT_CMP_B1 = 8;
    localparam int ACT_CMP_B2 = 10;
    localparam int ACT_WIDTH = 12;
    localparam int ST_TRIP = 0;
    localparam int ST_CMP_A1 = 1;
    localparam int ST_CMP_A2 = 2;
    localparam int ST_CMP_B1 = 3;
    localparam int ST_CMP_B2 = 4;
    localparam int ST_WIDTH = 5;
    // ==================================================
    // reset values
    localparam logic [7:0] RST_SRC_SEL = 8'h00;
    localparam logic [11:0] RST_ACT_CTL = 12'h000;
    localparam logic [4:0] RST_STATUS = 5'h00;
    localparam logic [4:0] RST_INT_EN = 5'h00;
    // ==================================================
    // action encodings
    localparam logic [1:0] ACT_HIZ = 2'h0;
    localparam logic [1:0] ACT_HIGH = 2'h1;
    localparam logic [1:0] ACT_LOW = 2'h2;
    localparam logic [1:0] ACT_NONE = 2'h3;
endpackage : trp_pkg

// file: trp_pin_override.sv
// per-pin override: picks the winning trip action and drives the pin
`timescale 1ns/100ps
module trp_pin_override
    import trp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic pwmIn,
    input wire logic tripOn,
    input wire logic [1:0] tripAct,
    input wire logic evt2On,
    input wire logic [1:0] evt2Act,
    input wire logic evt1On,
    input wire logic [1:0] evt1Act,
    output logic pinOut,
    output logic pinOeN
);
    // ==================================================
    // action priority: cycle trip, then event 2, then event 1
    logic [1:0] act;

    always_comb begin
        act = ACT_NONE;
        if (tripOn && tripAct != ACT_NONE) begin
            act = tripAct;
        end else if (evt2On && evt2Act != ACT_NONE) begin
            act = evt2Act;
        end else if (evt1On && evt1Act != ACT_NONE) begin
            act = evt1Act;
        end
    end

    // ==================================================
    // pin drive; released (hi-z) in reset for safety
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pinOut <= 1'b0;
            pinOeN <= 1'b1;
        end else begin
            unique case (act)
                ACT_HIZ: begin
                    pinOut <= 1'b0;
                    pinOeN <= 1'b1;
                end
                ACT_HIGH: begin
                    pinOut <= 1'b1;
                    pinOeN <= 1'b0;
                end
                ACT_LOW: begin
                    pinOut <= 1'b0;
                    pinOeN <= 1'b0;
                end
                ACT_NONE: begin
                    pinOut <= pwmIn;
                    pinOeN <= 1'b0;
                end
            endcase
        end
    end
endmodule : trp_pin_override

// file: trp_trip_zone.sv
// trip select and action block with apb registers and interrupt
`timescale 1ns/100ps
module trp_trip_zone
    import trp_pkg::*;
#(
    parameter int NTRIP = 6
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NTRIP-1:0] tripInN,
    input wire logic cmpAEvt1,
    input wire logic cmpAEvt2,
    input wire logic cmpBEvt1,
    input wire logic cmpBEvt2,
    input wire logic ctrZero,
    input wire logic pwmInA,
    input wire logic pwmInB,
    output logic pwmOutA,
    output logic pwmOutAOeN,
    output logic pwmOutB,
    output logic pwmOutBOeN,
    output logic irq
);
    // ==================================================
    // elaboration check
    generate
        if (NTRIP != 6) begin : g_bad_ntrip
            $error("trp_trip_zone: NTRIP must be 6");
        end
    endgenerate

    // ==================================================
    // registers
    logic [SEL_WIDTH-1:0] srcSel_ff;
    logic [ACT_WIDTH-1:0] actCtl_ff;
    logic [ST_WIDTH-1:0] status_ff;
    logic [ST_WIDTH-1:0] intEn_ff;
    logic cycleTrip_ff;
    logic [NTRIP-1:0] tripMeta_ff;
    logic [NTRIP-1:0] tripSync_ff;
    logic [31:0] rdData_ff;
    logic nxt_cycleTrip;
    logic cbcSrc;
    logic wrEn;
    logic setupRd;
    logic mapped;
    logic [ST_WIDTH-1:0] events;

    // ==================================================
    // trip pin synchroniser, idle high
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tripMeta_ff <= '1;
            tripSync_ff <= '1;
        end else begin
            tripMeta_ff <= tripInN;
            tripSync_ff <= tripMeta_ff;
        end
    end

    // ==================================================
    // cycle trip source and state
    always_comb begin
        cbcSrc = |(~tripSync_ff & srcSel_ff[SEL_TRIP_LSB +: NTRIP]);
        if (srcSel_ff[SEL_CMP_A2] && cmpAEvt2) begin
            cbcSrc = 1'b1;
        end
        if (srcSel_ff[SEL_CMP_B2] && cmpBEvt2) begin
            cbcSrc = 1'b1;
        end
    end

    // source wins over counter zero so a held fault never releases
    always_comb begin
        nxt_cycleTrip = cycleTrip_ff;
        if (cbcSrc) begin
            nxt_cycleTrip = 1'b1;
        end else if (ctrZero) begin
            nxt_cycleTrip = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cycleTrip_ff <= 1'b0;
        end else begin
            cycleTrip_ff <= nxt_cycleTrip;
        end
    end

    // ==================================================
    // output overrides
    trp_pin_override u_pinA (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pwmIn(pwmInA),
        .tripOn(cycleTrip_ff),
        .tripAct(actCtl_ff[ACT_TRIP_A +: 2]),
        .evt2On(cmpAEvt2),
        .evt2Act(actCtl_ff[ACT_CMP_A2 +: 2]),
        .evt1On(cmpAEvt1),
        .evt1Act(actCtl_ff[ACT_CMP_A1 +: 2]),
        .pinOut(pwmOutA),
        .pinOeN(pwmOutAOeN)
    );

    trp_pin_override u_pinB (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pwmIn(pwmInB),
        .tripOn(cycleTrip_ff),
        .tripAct(actCtl_ff[ACT_TRIP_B +: 2]),
        .evt2On(cmpBEvt2),
        .evt2Act(actCtl_ff[ACT_CMP_B2 +: 2]),
        .evt1On(cmpBEvt1),
        .evt1Act(actCtl_ff[ACT_CMP_B1 +: 2]),
        .pinOut(pwmOutB),
        .pinOeN(pwmOutBOeN)
    );

    // ==================================================
    // apb slave: zero wait, read data latched in setup
    assign pready = 1'b1;
    assign wrEn = psel && penable && pwrite;
    assign setupRd = psel && !penable && !pwrite;

    always_comb begin
        unique case (paddr)
            OFS_SRC_SEL, OFS_ACT_CTL, OFS_STATUS, OFS_CLEAR,
            OFS_INT_EN, OFS_TRIP_STATE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            srcSel_ff <= RST_SRC_SEL;
        end else if (wrEn && paddr == OFS_SRC_SEL) begin
            srcSel_ff <= pwdata[SEL_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            actCtl_ff <= RST_ACT_CTL;
        end else if (wrEn && paddr == OFS_ACT_CTL) begin
            actCtl_ff <= pwdata[ACT_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            intEn_ff <= RST_INT_EN;
        end else if (wrEn && paddr == OFS_INT_EN) begin
            intEn_ff <= pwdata[ST_WIDTH-1:0];
        end
    end

    // reserved bits stay zero by width, clear register reads zero
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdData_ff <= 32'h0000_0000;
        end else if (setupRd) begin
            unique case (paddr)
                OFS_SRC_SEL: rdData_ff <= {24'h000000, srcSel_ff};
                OFS_ACT_CTL: rdData_ff <= {20'h00000, actCtl_ff};
                OFS_STATUS: rdData_ff <= {27'h0000000, status_ff};
                OFS_INT_EN: rdData_ff <= {27'h0000000, intEn_ff};
                OFS_TRIP_STATE: rdData_ff <= {31'h00000000, cycleTrip_ff};
                default: rdData_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = rdData_ff;

    // ==================================================
    // interrupt status: set beats a clear in the same cycle
    always_comb begin
        events = '0;
        events[ST_TRIP] = cbcSrc;
        events[ST_CMP_A1] = cmpAEvt1;
        events[ST_CMP_A2] = cmpAEvt2;
        events[ST_CMP_B1] = cmpBEvt1;
        events[ST_CMP_B2] = cmpBEvt2;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            status_ff <= RST_STATUS;
        end else if (wrEn && paddr == OFS_CLEAR) begin
            status_ff <= (status_ff & ~pwdata[ST_WIDTH-1:0]) | events;
        end else begin
            status_ff <= status_ff | events;
        end
    end

    assign irq = |(status_ff & intEn_ff);

    // ==================================================
    // checks
    sequence s_src_seen;
        cbcSrc;
    endsequence

    sequence s_zero_release;
        cycleTrip_ff && ctrZero && !cbcSrc;
    endsequence

    property p_trip_set;
        @(posedge sys_clk) disable iff (!nrst)
        s_src_seen |=> cycleTrip_ff;
    endproperty
    a_trip_set: assert property (p_trip_set)
        else $error("enabled trip source did not raise the trip");

    property p_trip_release;
        @(posedge sys_clk) disable iff (!nrst)
        s_zero_release |=> !cycleTrip_ff ##1 (pwmOutA == $past(pwmInA));
    endproperty
    a_trip_release: assert property (p_trip_release)
        else $error("trip not released at counter zero");

    property p_trip_hold;
        @(posedge sys_clk) disable iff (!nrst)
        ctrZero && cbcSrc |=> cycleTrip_ff [*2];
    endproperty
    a_trip_hold: assert property (p_trip_hold)
        else $error("held source released at counter zero");

    property p_idle_stays;
        @(posedge sys_clk) disable iff (!nrst)
        !cycleTrip_ff && !cbcSrc && srcSel_ff == 8'h00 |=> !cycleTrip_ff;
    endproperty
    a_idle_stays: assert property (p_idle_stays)
        else $error("trip raised with no source enabled");

    property p_cmp_b2_sel;
        @(posedge sys_clk) disable iff (!nrst)
        cmpBEvt2 && srcSel_ff[SEL_CMP_B2] |=> cycleTrip_ff;
    endproperty
    a_cmp_b2_sel: assert property (p_cmp_b2_sel)
        else $error("compare b event 2 did not trip");

    property p_cmp_a2_sel;
        @(posedge sys_clk) disable iff (!nrst)
        cmpAEvt2 && srcSel_ff[SEL_CMP_A2] |=> cycleTrip_ff;
    endproperty
    a_cmp_a2_sel: assert property (p_cmp_a2_sel)
        else $error("compare a event 2 did not trip");

    property p_out_a_low;
        @(posedge sys_clk) disable iff (!nrst)
        cycleTrip_ff && actCtl_ff[1:0] == 2'h2 |=> !pwmOutA && !pwmOutAOeN;
    endproperty
    a_out_a_low: assert property (p_out_a_low)
        else $error("output a not forced low on trip");

    property p_out_b_hiz;
        @(posedge sys_clk) disable iff (!nrst)
        cycleTrip_ff && actCtl_ff[3:2] == 2'h0 |=> pwmOutBOeN;
    endproperty
    a_out_b_hiz: assert property (p_out_b_hiz)
        else $error("output b not released to hi-z on trip");

    property p_cmp_a1_high;
        @(posedge sys_clk) disable iff (!nrst)
        !cycleTrip_ff && !cmpAEvt2 && cmpAEvt1 && actCtl_ff[5:4] == 2'h1
        |=> pwmOutA && !pwmOutAOeN;
    endproperty
    a_cmp_a1_high: assert property (p_cmp_a1_high)
        else $error("compare a event 1 did not force a high");

    property p_cmp_b1_low;
        @(posedge sys_clk) disable iff (!nrst)
        !cycleTrip_ff && !cmpBEvt2 && cmpBEvt1 && actCtl_ff[9:8] == 2'h2
        |=> !pwmOutB && !pwmOutBOeN;
    endproperty
    a_cmp_b1_low: assert property (p_cmp_b1_low)
        else $error("compare b event 1 did not force b low");

    property p_cmp_a2_low;
        @(posedge sys_clk) disable iff (!nrst)
        !cycleTrip_ff && cmpAEvt2 && actCtl_ff[ACT_CMP_A2 +: 2] == ACT_LOW
        |=> !pwmOutA && !pwmOutAOeN;
    endproperty
    a_cmp_a2_low: assert property (p_cmp_a2_low)
        else $error("compare a event 2 did not force a low");

    property p_cmp_b2_hiz;
        @(posedge sys_clk) disable iff (!nrst)
        !cycleTrip_ff && cmpBEvt2 && actCtl_ff[ACT_CMP_B2 +: 2] == ACT_HIZ
        |=> pwmOutBOeN;
    endproperty
    a_cmp_b2_hiz: assert property (p_cmp_b2_hiz)
        else $error("compare b event 2 did not release b");

    property p_rsvd_zero;
        @(posedge sys_clk) disable iff (!nrst)
        psel && !penable && !pwrite && paddr == OFS_ACT_CTL
        |=> prdata[31:12] == 20'h00000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved action bits read nonzero");
endmodule : trp_trip_zone

// file: trp_stage_model.sv
// model of the power stage: trip pins and upstream pwm levels
`timescale 1ns/100ps
module trp_stage_model (
    input wire logic sys_clk,
    input wire logic [5:0] tripReq,
    input wire logic lvlA,
    input wire logic lvlB,
    output logic [5:0] tripInN,
    output logic pwmInA,
    output logic pwmInB
);
    // ==================================================
    // pins idle high on their pull-ups, a fault pulls one low
    always @(posedge sys_clk) begin
        tripInN <= ~tripReq;
        pwmInA <= lvlA;
        pwmInB <= lvlB;
    end
endmodule : trp_stage_model

// file: pwm_trip_select_action_tb_top.sv
// self-checking bench for the trip select and action block
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module pwm_trip_select_action_tb_top
    import trp_pkg::*;
;
    logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, pwmInA, pwmInB, irq, err;
    logic pwmOutA, pwmOutAOeN, pwmOutB, pwmOutBOeN;
    logic [5:0] tripReq = '0, tripInN;
    logic cmpAEvt1 = 0, cmpAEvt2 = 0, cmpBEvt1 = 0, cmpBEvt2 = 0;
    logic ctrZero = 0, lvlA = 0, lvlB = 0;
    int miscompares = 0, num_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    trp_trip_zone #(.NTRIP(6)) uut (.sys_clk(sys_clk), .nrst(nrst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tripInN(tripInN), .cmpAEvt1(cmpAEvt1),
        .cmpAEvt2(cmpAEvt2), .cmpBEvt1(cmpBEvt1), .cmpBEvt2(cmpBEvt2),
        .ctrZero(ctrZero), .pwmInA(pwmInA), .pwmInB(pwmInB),
        .pwmOutA(pwmOutA), .pwmOutAOeN(pwmOutAOeN), .pwmOutB(pwmOutB),
        .pwmOutBOeN(pwmOutBOeN), .irq(irq));
    trp_stage_model model (.sys_clk(sys_clk), .tripReq(tripReq),
        .lvlA(lvlA), .lvlB(lvlB), .tripInN(tripInN), .pwmInA(pwmInA),
        .pwmInB(pwmInB));
    // ==================================================
    // helpers
    function automatic logic [1:0] pin(logic [1:0] c, logic p);
        case (c)
            ACT_HIZ: pin = 2'b10;
            ACT_HIGH: pin = 2'b01;
            ACT_LOW: pin = 2'b00;
            default: pin = {1'b0, p};
        endcase
    endfunction : pin
    task report_and_stop;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        if (pready !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
    endtask : xfer
    // wait n edges, then look at settled outputs
    task settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle
    task zero;
        @(posedge sys_clk);
        ctrZero <= 1;
        @(posedge sys_clk);
        ctrZero <= 0;
    endtask : zero
    // ==================================================
    // scenarios
    task t_regs;
        xfer(0, OFS_ACT_CTL, 0); `CHK(rd, 32'h0)
        xfer(1, OFS_ACT_CTL, 32'hffffffff);
        xfer(0, OFS_ACT_CTL, 0); `CHK(rd, 32'h00000fff)
        xfer(1, OFS_SRC_SEL, 32'hffffffff);
        xfer(0, OFS_SRC_SEL, 0); `CHK(rd, 32'h000000ff)
        xfer(1, 12'h0f0, 32'h1); `CHK(err, 1'b1)
        xfer(0, 12'h0f0, 0); `CHK(rd, 32'h0)
    endtask : t_regs
    task t_cmp_src;
        for (int k = 0; k < 4; k++) begin
            xfer(1, OFS_SRC_SEL, k[0] ? 32'h80 : 32'h40);
            @(posedge sys_clk);
            cmpAEvt2 <= !k[1];
            cmpBEvt2 <= k[1];
            settle(3);
            xfer(0, OFS_TRIP_STATE, 0);
            `CHK(rd[0], 1'(k[0] == k[1]))
            cmpAEvt2 <= 0; cmpBEvt2 <= 0;
            zero();
        end
    endtask : t_cmp_src
    task t_pins;
        xfer(1, OFS_ACT_CTL, 32'hff8);
        lvlA <= 1; lvlB <= 1;
        for (int i = 0; i < 6; i++) begin
            xfer(1, OFS_SRC_SEL, 32'h1 << i);
            tripReq <= 6'h1 << ((i + 1) % 6);
            settle(6); `CHK({pwmOutAOeN, pwmOutA}, 2'b01)
            @(posedge sys_clk);
            tripReq <= 6'h1 << i;
            settle(6); `CHK({pwmOutAOeN, pwmOutA}, 2'b10)
            `CHK({pwmOutBOeN, pwmOutB}, 2'b00)
            @(posedge sys_clk);
            tripReq <= 0;
            settle(4);
            zero();
        end
    endtask : t_pins
    task t_codes;
        xfer(1, OFS_SRC_SEL, 32'h80);
        lvlA <= 0; lvlB <= 1;
        for (int c = 0; c < 4; c++) begin
            xfer(1, OFS_ACT_CTL, 32'hff0 | c | ((3 - c) << 2));
            cmpBEvt2 <= 1;
            settle(3); `CHK({pwmOutAOeN, pwmOutA}, pin(2'(c), 1'b0))
            `CHK({pwmOutBOeN, pwmOutB}, pin(2'(3 - c), 1'b1))
            @(posedge sys_clk);
            cmpBEvt2 <= 0;
            zero();
        end
    endtask : t_codes
    task t_clear;
        xfer(1, OFS_ACT_CTL, 32'hff1);
        cmpBEvt2 <= 1;
        zero();
        settle(3); `CHK({pwmOutAOeN, pwmOutA}, 2'b01)
        @(posedge sys_clk);
        cmpBEvt2 <= 0;
        settle(6); `CHK({pwmOutBOeN, pwmOutB}, 2'b10)
        zero();
        settle(3); `CHK({pwmOutAOeN, pwmOutA}, 2'b00)
    endtask : t_clear
    task t_evt;
        logic [7:0] ea, eb;
        ea = 8'b00000001;
        eb = 8'b10000101;
        // event 2 outranks event 1 on a pin when both are high
        xfer(1, OFS_SRC_SEL, 0);
        xfer(1, OFS_ACT_CTL, 32'h29f);
        lvlA <= 0; lvlB <= 1;
        for (int e = 0; e < 4; e++) begin
            @(posedge sys_clk);
            {cmpBEvt2, cmpBEvt1, cmpAEvt2, cmpAEvt1} <=
                (4'h1 << e) | ((e == 1) ? 4'h1 : 4'h0);
            settle(3); `CHK({pwmOutAOeN, pwmOutA}, ea[2*e+:2])
            `CHK({pwmOutBOeN, pwmOutB}, eb[2*e+:2])
        end
        xfer(1, OFS_ACT_CTL, 32'hfff);
        settle(2); `CHK({pwmOutBOeN, pwmOutB}, 2'b01)
        @(posedge sys_clk);
        {cmpBEvt2, cmpBEvt1, cmpAEvt2, cmpAEvt1} <= 4'h0;
    endtask : t_evt
    task t_irq;
        xfer(1, OFS_CLEAR, 32'h1f);
        xfer(1, OFS_INT_EN, 32'h1);
        xfer(1, OFS_SRC_SEL, 32'h80);
        cmpBEvt2 <= 1;
        @(posedge sys_clk);
        cmpBEvt2 <= 0;
        settle(3); `CHK(irq, 1'b1)
        xfer(0, OFS_STATUS, 0); `CHK(rd[0], 1'b1)
        xfer(1, OFS_INT_EN, 0);
        settle(1); `CHK(irq, 1'b0)
        zero();
        xfer(1, OFS_CLEAR, 32'h1f);
        xfer(0, OFS_STATUS, 0); `CHK(rd[4:0], 5'h0)
        xfer(1, OFS_INT_EN, 32'h1f);
        settle(1); `CHK(irq, 1'b0)
    endtask : t_irq
    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1;
        t_regs();
        t_cmp_src();
        t_pins();
        t_codes();
        t_clear();
        t_evt();
        t_irq();
        report_and_stop();
    end
    // a hang counts against the run
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        report_and_stop();
    end
endmodule : pwm_trip_select_action_tb_top
